/* rtl/chg_ctrl_irq.sv */
/*
 * Second control register and first two interrupt flag registers of the
 * charger, reached through an I2C target with an auto-incrementing pointer.
 * Assumes analog comparator levels and I2C pins are asynchronous, and that
 * the mask, summary, soft reset and boost mode inputs come from logic on clk.
 */
`include "chg_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module chg_ctrl_irq #(
	parameter logic [6:0] I2C_ADDR = `CHG_I2C_ADDR_DEFAULT
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic clk_en,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	input wire chg_pkg::chg_cond_s cond_i,
	input wire logic second_irq_pending,
	input wire logic int_mask,
	input wire logic soft_reset,
	input wire logic otg_mode,
	output chg_pkg::chg_ctrl_s ctrl,
	output logic irq_active
);

	logic [9:0] sync1_q, sync1_d, sync2_q, sync2_d;
	logic [1:0] line_q, line_d;
	chg_pkg::chg_i2c_e st_q, st_d;
	logic [3:0] cnt_q, cnt_d;
	logic [7:0] sh_q, sh_d, ptr_q, ptr_d;
	logic rw_q, rw_d, nack_q, nack_d, oe_q, oe_d;
	logic wr_stb, rd_stb;
	logic [7:0] wr_data, rd_ptr;
	logic [7:0] charger_control_two_q, charger_control_two_d, tirq_q, tirq_d, cirq_q, cirq_d;
	chg_pkg::chg_ctrl_s ctrl_q, ctrl_d;
	logic irq_q, irq_d;
	logic scl_s, sda_s, scl_rise, scl_fall, start_c, stop_c;
	chg_pkg::chg_cond_s cond_s;
	logic [7:0] tcond, ccond;

	// Register contents as seen by a read; reserved bits read zero
	function automatic logic [7:0] read_byte(input logic [7:0] p, input logic [7:0] c2,
			input logic [7:0] t, input logic [7:0] c1, input logic sum);
		logic [7:0] v;
		v = 8'h00;
		case (p)
			`CHG_OFS_CHARGER_CONTROL_TWO: v = c2 & `CHG_WMASK_CHARGER_CONTROL_TWO;
			`CHG_OFS_TEMP_IRQ: v = t & `CHG_MASK_TEMP_IRQ;
			`CHG_OFS_CHG_IRQ1: begin
				v = c1 & `CHG_MASK_CHG_IRQ1;
				// Summary is read live; it has no flag of its own here
				v[`CHG_BIT_SECOND_SUMMARY] = sum;
			end
			default: v = 8'h00;
		endcase
		return v;
	endfunction

	// Two-flop synchronisers, third stage for I2C edge detection
	// Comparator levels ride the same chain, so flags lag a pin change by three edges
	always_comb begin
		sync1_d = {scl_i, sda_i, cond_i};
		sync2_d = sync1_q;
		line_d = sync2_q[9:8];
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			sync1_q <= 10'h300;
			sync2_q <= 10'h300;
			line_q <= 2'h3;
		end else if (clk_en) begin
			sync1_q <= sync1_d;
			sync2_q <= sync2_d;
			line_q <= line_d;
		end
	end

	assign scl_s = sync2_q[9];
	assign sda_s = sync2_q[8];
	assign cond_s = sync2_q[7:0];
	assign scl_rise = scl_s && !line_q[1];
	assign scl_fall = !scl_s && line_q[1];
	// START and STOP are SDA edges seen while SCL stays high
	assign start_c = scl_s && line_q[1] && !sda_s && line_q[0];
	assign stop_c = scl_s && line_q[1] && sda_s && !line_q[0];

	// I2C target: address, pointer, then write bytes or read bytes
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		sh_d = sh_q;
		ptr_d = ptr_q;
		rw_d = rw_q;
		nack_d = nack_q;
		oe_d = oe_q;
		wr_stb = 1'b0;
		rd_stb = 1'b0;
		wr_data = sh_q;
		rd_ptr = ptr_q;
		if (start_c) begin
			st_d = chg_pkg::CHG_ADDR;
			cnt_d = 4'h0;
			oe_d = 1'b0;
		end else if (stop_c) begin
			// A partial byte at STOP is dropped; the pointer keeps its value
			st_d = chg_pkg::CHG_IDLE;
			oe_d = 1'b0;
		end else if (scl_rise) begin
			case (st_q)
				chg_pkg::CHG_ADDR, chg_pkg::CHG_PTR, chg_pkg::CHG_WDATA: begin
					sh_d = {sh_q[6:0], sda_s};
					cnt_d = cnt_q + 4'h1;
				end
				chg_pkg::CHG_RDATA: cnt_d = cnt_q + 4'h1;
				// A host NACK ends the read until the next START
				chg_pkg::CHG_RACK: nack_d = sda_s;
				default: cnt_d = cnt_q;
			endcase
		end else if (scl_fall) begin
			case (st_q)
				chg_pkg::CHG_ADDR: begin
					if (cnt_q == 4'h8) begin
						if (sh_q[7:1] == I2C_ADDR) begin
							st_d = chg_pkg::CHG_ADDR_ACK;
							rw_d = sh_q[0];
							oe_d = 1'b1;
						end else begin
							st_d = chg_pkg::CHG_IDLE;
						end
					end
				end
				chg_pkg::CHG_ADDR_ACK, chg_pkg::CHG_RACK: begin
					cnt_d = 4'h0;
					if (!rw_q) begin
						st_d = chg_pkg::CHG_PTR;
						oe_d = 1'b0;
					end else if (st_q == chg_pkg::CHG_RACK && nack_q) begin
						st_d = chg_pkg::CHG_IDLE;
						oe_d = 1'b0;
					end else begin
						st_d = chg_pkg::CHG_RDATA;
						rd_stb = 1'b1;
						// Loading a byte is the read that clears its flags
						sh_d = read_byte(ptr_q, charger_control_two_q, tirq_q, cirq_q, second_irq_pending);
						oe_d = !sh_d[7];
						ptr_d = ptr_q + 8'h01;
					end
				end
				chg_pkg::CHG_PTR: begin
					if (cnt_q == 4'h8) begin
						st_d = chg_pkg::CHG_PTR_ACK;
						ptr_d = sh_q;
						oe_d = 1'b1;
					end
				end
				chg_pkg::CHG_PTR_ACK, chg_pkg::CHG_WACK: begin
					st_d = chg_pkg::CHG_WDATA;
					cnt_d = 4'h0;
					oe_d = 1'b0;
				end
				chg_pkg::CHG_WDATA: begin
					if (cnt_q == 4'h8) begin
						st_d = chg_pkg::CHG_WACK;
						wr_stb = 1'b1;
						ptr_d = ptr_q + 8'h01;
						oe_d = 1'b1;
					end
				end
				chg_pkg::CHG_RDATA: begin
					if (cnt_q == 4'h8) begin
						st_d = chg_pkg::CHG_RACK;
						oe_d = 1'b0;
					end else begin
						sh_d = {sh_q[6:0], 1'b0};
						oe_d = !sh_q[6];
					end
				end
				default: st_d = chg_pkg::CHG_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			st_q <= chg_pkg::CHG_IDLE;
			cnt_q <= 4'h0;
			sh_q <= 8'h00;
			ptr_q <= 8'h00;
			rw_q <= 1'b0;
			nack_q <= 1'b1;
			oe_q <= 1'b0;
		end else if (clk_en) begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			sh_q <= sh_d;
			ptr_q <= ptr_d;
			rw_q <= rw_d;
			nack_q <= nack_d;
			oe_q <= oe_d;
		end
	end

	// Condition levels placed at their flag positions
	always_comb begin
		tcond = 8'h00;
		tcond[`CHG_BIT_DIE_WARM] = cond_s.die_warm;
		tcond[`CHG_BIT_DIE_FIRST] = cond_s.die_first;
		tcond[`CHG_BIT_DIE_SECOND] = cond_s.die_second;
		tcond[`CHG_BIT_DIE_SHUTDOWN] = cond_s.die_shutdown;
		tcond[`CHG_BIT_USB_RANGE] = cond_s.usb_range;
		ccond = 8'h00;
		ccond[`CHG_BIT_INPUT_LOW] = cond_s.input_low;
		ccond[`CHG_BIT_INPUT_OVER] = cond_s.input_over;
		ccond[`CHG_BIT_BATTERY_OVER] = cond_s.battery_over;
	end

	// Register file, control outputs and interrupt line
	always_comb begin
		charger_control_two_d = charger_control_two_q;
		if (wr_stb && ptr_q == `CHG_OFS_CHARGER_CONTROL_TWO) begin
			charger_control_two_d = wr_data & `CHG_WMASK_CHARGER_CONTROL_TWO;
		end
		// Boost mode restores all but the transceiver bit; soft reset restores all
		if (soft_reset) begin
			charger_control_two_d = `CHG_RST_CHARGER_CONTROL_TWO;
		end else if (otg_mode) begin
			charger_control_two_d = (charger_control_two_d & `CHG_KEEP_OTG_CHARGER_CONTROL_TWO) | (`CHG_RST_CHARGER_CONTROL_TWO & ~`CHG_KEEP_OTG_CHARGER_CONTROL_TWO);
		end
		// A condition present in the clearing cycle keeps its flag set
		tirq_d = tirq_q;
		if (rd_stb && rd_ptr == `CHG_OFS_TEMP_IRQ) begin
			tirq_d = 8'h00;
		end
		tirq_d = (tirq_d | tcond) & `CHG_MASK_TEMP_IRQ;
		cirq_d = cirq_q;
		if (rd_stb && rd_ptr == `CHG_OFS_CHG_IRQ1) begin
			cirq_d = 8'h00;
		end
		cirq_d = (cirq_d | ccond) & `CHG_MASK_CHG_IRQ1;
		// Reset-type clears win even over a condition that is still present
		if (soft_reset) begin
			tirq_d = 8'h00;
			cirq_d = 8'h00;
		end else if (otg_mode) begin
			tirq_d[`CHG_BIT_USB_RANGE] = 1'b0;
			cirq_d = 8'h00;
		end
		ctrl_d.watchdog_disable = charger_control_two_d[`CHG_BIT_WATCHDOG_DISABLE];
		ctrl_d.charge_timer_disable = charger_control_two_d[`CHG_BIT_CHARGE_TIMER_DISABLE];
		ctrl_d.power_path_enable = charger_control_two_d[`CHG_BIT_POWER_PATH_ENABLE];
		ctrl_d.trans_supply_enable = charger_control_two_d[`CHG_BIT_TRANS_SUPPLY_ENABLE];
		ctrl_d.limit_source_pin_select = charger_control_two_d[`CHG_BIT_LIMIT_SOURCE_PIN_SELECT];
		ctrl_d.input_limit_enable = charger_control_two_d[`CHG_BIT_INPUT_LIMIT_ENABLE];
		ctrl_d.auto_current_enable = charger_control_two_d[`CHG_BIT_AUTO_CURRENT_ENABLE];
		// Built from next-state flags so the line moves with them, not a cycle later
		irq_d = !int_mask && ((|tirq_d) || (|cirq_d) || second_irq_pending);
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			charger_control_two_q <= `CHG_RST_CHARGER_CONTROL_TWO;
			tirq_q <= 8'h00;
			cirq_q <= 8'h00;
			ctrl_q <= chg_pkg::chg_ctrl_s'(7'h0e);
			irq_q <= 1'b0;
		end else if (clk_en) begin
			charger_control_two_q <= charger_control_two_d;
			tirq_q <= tirq_d;
			cirq_q <= cirq_d;
			ctrl_q <= ctrl_d;
			irq_q <= irq_d;
		end
	end

	// Open-drain data line: only the enable ever changes
	assign sda_o = 1'b0;
	assign sda_oe = oe_q;
	assign ctrl = ctrl_q;
	assign irq_active = irq_q;

endmodule

`default_nettype wire

/* rtl/chg_regs.svh */
/*
 * Register offsets, field positions, reset values and masks of the charger
 * control and interrupt flag registers. Assumes an 8-bit register pointer.
 */
`ifndef CHG_REGS_SVH
`define CHG_REGS_SVH

`define CHG_OFS_CHARGER_CONTROL_TWO 8'h02
`define CHG_OFS_TEMP_IRQ 8'h03
`define CHG_OFS_CHG_IRQ1 8'h04

`define CHG_BIT_WATCHDOG_DISABLE 7
`define CHG_BIT_CHARGE_TIMER_DISABLE 6
`define CHG_BIT_POWER_PATH_ENABLE 5
`define CHG_BIT_TRANS_SUPPLY_ENABLE 4
`define CHG_BIT_LIMIT_SOURCE_PIN_SELECT 2
`define CHG_BIT_INPUT_LIMIT_ENABLE 1
`define CHG_BIT_AUTO_CURRENT_ENABLE 0

`define CHG_BIT_DIE_WARM 5
`define CHG_BIT_DIE_FIRST 4
`define CHG_BIT_DIE_SECOND 3
`define CHG_BIT_DIE_SHUTDOWN 2
`define CHG_BIT_USB_RANGE 0

`define CHG_BIT_INPUT_LOW 4
`define CHG_BIT_INPUT_OVER 3
`define CHG_BIT_BATTERY_OVER 1
`define CHG_BIT_SECOND_SUMMARY 0

`define CHG_RST_CHARGER_CONTROL_TWO 8'h16
`define CHG_WMASK_CHARGER_CONTROL_TWO 8'hf7
`define CHG_KEEP_OTG_CHARGER_CONTROL_TWO 8'h10
`define CHG_MASK_TEMP_IRQ 8'h3d
`define CHG_MASK_CHG_IRQ1 8'h1a

`define CHG_I2C_ADDR_DEFAULT 7'h35

`endif

/* rtl/chg_pkg.sv */
/*
 * Types of the charger control and interrupt register block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package chg_pkg;

	typedef enum logic [3:0] {
		CHG_IDLE = 4'h0,
		CHG_ADDR = 4'h1,
		CHG_ADDR_ACK = 4'h3,
		CHG_PTR = 4'h2,
		CHG_PTR_ACK = 4'h6,
		CHG_WDATA = 4'h7,
		CHG_WACK = 4'h5,
		CHG_RDATA = 4'h4,
		CHG_RACK = 4'hc
	} chg_i2c_e;

	typedef struct packed {
		logic watchdog_disable;
		logic charge_timer_disable;
		logic power_path_enable;
		logic trans_supply_enable;
		logic limit_source_pin_select;
		logic input_limit_enable;
		logic auto_current_enable;
	} chg_ctrl_s;

	typedef struct packed {
		logic die_warm;
		logic die_first;
		logic die_second;
		logic die_shutdown;
		logic usb_range;
		logic input_low;
		logic input_over;
		logic battery_over;
	} chg_cond_s;

endpackage

/* test/chg_ctrl_irq_monitor.sv */
/* Port checker of the charger register block.
   Assumes it is bound to chg_ctrl_irq and that SCL phases last >= 10 clk. */
`timescale 1ns/10ps
`default_nettype none
module chg_ctrl_irq_monitor (
	input wire logic clk,
	input wire logic resetn,
	input wire logic clk_en,
	input wire logic scl_i,
	input wire logic sda_oe,
	input wire chg_pkg::chg_cond_s cond_i,
	input wire logic second_irq_pending,
	input wire logic int_mask,
	input wire logic soft_reset,
	input wire logic otg_mode,
	input wire chg_pkg::chg_ctrl_s ctrl,
	input wire logic irq_active
);
	default clocking dc @(posedge clk); endclocking
	reset_ctrl_a: assert property (!resetn && clk_en |=> ctrl == 7'h0e)
		else $error("ctrl not at reset value");
	reset_quiet_a: assert property (!resetn && clk_en |=> !sda_oe && !irq_active)
		else $error("outputs active in reset");
	mask_quiet_a: assert property (disable iff (!resetn)
		int_mask && clk_en |=> !irq_active) else $error("irq active while masked");
	summary_irq_a: assert property (disable iff (!resetn)
		!int_mask && second_irq_pending && clk_en |=> irq_active)
		else $error("summary did not raise irq");
	flag_raise_a: assert property (disable iff (!resetn)
		(cond_i != 8'h00 && !int_mask && clk_en && !soft_reset && !otg_mode) [*4]
		|=> irq_active) else $error("condition did not raise irq");
	soft_reset_a: assert property (disable iff (!resetn)
		soft_reset && clk_en |-> ##2 ctrl == 7'h0e) else $error("soft reset missed");
	otg_keep_a: assert property (disable iff (!resetn)
		otg_mode && clk_en |-> ##2 ctrl[6:4] == 3'h0 && ctrl[2:0] == 3'h6
		&& ctrl[3] == $past(ctrl[3], 2)) else $error("boost mode reset wrong");
	ctrl_hold_a: assert property (disable iff (!resetn)
		$changed(ctrl) |-> !scl_i || $past(soft_reset) || $past(otg_mode))
		else $error("ctrl changed outside a write");
endmodule
bind chg_ctrl_irq chg_ctrl_irq_monitor chg_ctrl_irq_monitor_inst (.clk(clk), .resetn(resetn),
	.clk_en(clk_en), .scl_i(scl_i), .sda_oe(sda_oe), .cond_i(cond_i),
	.second_irq_pending(second_irq_pending), .int_mask(int_mask), .soft_reset(soft_reset),
	.otg_mode(otg_mode), .ctrl(ctrl), .irq_active(irq_active));
`default_nettype wire

/* test/chg_host_model.sv */
/* I2C host controller model for the charger register block.
   Assumes sda is the wired-and bus level with a pull-up. */
`timescale 1ns/10ps
`default_nettype none
module chg_host_model #(
	parameter logic [6:0] ADDR = 7'h35
) (
	input wire logic clk,
	input wire logic sda,
	output logic scl,
	output logic sda_pull
);
	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end
	// Data moves one clk after SCL so no edge pair looks like START or STOP
	task automatic pin(input logic c, input logic p);
		scl = c;
		@(negedge clk);
		sda_pull = p;
		repeat (9) @(negedge clk);
	endtask
	task automatic xfer(input logic [7:0] w, input logic last, output logic [7:0] r,
		output logic ack);
		logic [8:0] s;
		s = {w, last};
		for (int i = 8; i >= 0; i--) begin
			pin(1'b0, !s[i]);
			pin(1'b1, !s[i]);
			s[i] = sda;
		end
		r = s[8:1];
		ack = !s[0];
	endtask
	task automatic start();
		pin(1'b0, 1'b0);
		pin(1'b1, 1'b0);
		pin(1'b1, 1'b1);
	endtask
	task automatic stop();
		pin(1'b0, 1'b1);
		pin(1'b1, 1'b1);
		pin(1'b1, 1'b0);
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] v,
		output logic ok);
		logic [7:0] r;
		logic k1, k2, k3;
		start();
		xfer({a, 1'b0}, 1'b1, r, k1);
		xfer(p, 1'b1, r, k2);
		xfer(v, 1'b1, r, k3);
		stop();
		ok = k1 & k2 & k3;
	endtask
	// Reads two bytes, pointer and pointer plus one
	task automatic rd(input logic [7:0] p, output logic [15:0] d);
		logic [7:0] r;
		logic k;
		start();
		xfer({ADDR, 1'b0}, 1'b1, r, k);
		xfer(p, 1'b1, r, k);
		start();
		xfer({ADDR, 1'b1}, 1'b1, r, k);
		xfer(8'hff, 1'b0, d[15:8], k);
		xfer(8'hff, 1'b1, d[7:0], k);
		stop();
	endtask
endmodule
`default_nettype wire

/* test/tb.sv */
/* Self-checking bench of the charger register block.
   Assumes the host model owns SCL and SDA has a pull-up. */
`timescale 1ns/10ps
`default_nettype none
module tb;
	localparam logic [15:0] FLAG_MAP [8] = '{16'h0002, 16'h0008, 16'h0010, 16'h0100,
		16'h0400, 16'h0800, 16'h1000, 16'h2000};
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic soft_reset = 1'b0;
	logic otg_mode = 1'b0;
	logic int_mask = 1'b1;
	logic pend = 1'b0;
	chg_pkg::chg_cond_s cond = '0;
	chg_pkg::chg_ctrl_s ctrl;
	logic clk_en = 1'b1;
	logic scl, pull, sda_oe, sda_o, irq, ok;
	logic [15:0] d;
	wire logic sda = !(pull | (sda_oe & !sda_o));
	int n_errors = 0;
	int checks_done = 0;
	chg_ctrl_irq chg_ctrl_irq_inst (.clk(clk), .resetn(resetn), .clk_en(clk_en), .scl_i(scl),
		.sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .cond_i(cond), .second_irq_pending(pend),
		.int_mask(int_mask), .soft_reset(soft_reset), .otg_mode(otg_mode), .ctrl(ctrl),
		.irq_active(irq));
	chg_host_model chg_host_model_inst (.clk(clk), .sda(sda), .scl(scl), .sda_pull(pull));
	initial begin
		forever #5 clk = ~clk;
	end
	task automatic wt(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic check(input string n, input logic [15:0] s, input logic [15:0] e);
		checks_done++;
		if (s !== e) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic t_reset();
		check("ctrl", {9'h0, ctrl}, 16'h000e);
		chg_host_model_inst.rd(8'h02, d);
		check("r02 r03", d, 16'h1600);
		chg_host_model_inst.rd(8'h04, d);
		check("r04", d, 16'h0000);
	endtask
	task automatic t_ctrl();
		logic [7:0] v;
		for (int i = 0; i < 8; i++) begin
			v = 8'h01 << i;
			chg_host_model_inst.wr(7'h35, 8'h02, v, ok);
			wt(4);
			check("ack", {15'h0, ok}, 16'h0001);
			check("ctrl", {9'h0, ctrl}, {9'h0, v[7:4], v[2:0]});
			chg_host_model_inst.rd(8'h02, d);
			check("r02", {8'h0, d[15:8]}, {8'h0, v & 8'hf7});
		end
	endtask
	task automatic t_refuse();
		chg_host_model_inst.wr(7'h36, 8'h02, 8'h00, ok);
		check("bad addr", {15'h0, ok}, 16'h0000);
		check("ctrl", {9'h0, ctrl}, 16'h0040);
		chg_host_model_inst.wr(7'h35, 8'h03, 8'hff, ok);
		chg_host_model_inst.rd(8'h03, d);
		check("r03 r04", d, 16'h0000);
	endtask
	task automatic t_flags();
		int_mask = 1'b0;
		for (int i = 0; i < 8; i++) begin
			cond = 8'h01 << i;
			wt(6);
			check("irq", {15'h0, irq}, 16'h0001);
			cond = '0;
			wt(6);
			chg_host_model_inst.rd(8'h03, d);
			check("flag", d, FLAG_MAP[i]);
			chg_host_model_inst.rd(8'h03, d);
			check("cleared", d, 16'h0000);
			check("irq", {15'h0, irq}, 16'h0000);
		end
		cond = 8'h08;
		wt(6);
		chg_host_model_inst.rd(8'h03, d);
		chg_host_model_inst.rd(8'h03, d);
		check("held", d, 16'h0100);
		cond = '0;
		wt(6);
		chg_host_model_inst.rd(8'h03, d);
	endtask
	task automatic t_mask();
		int_mask = 1'b1;
		pend = 1'b1;
		cond = 8'h04;
		wt(6);
		check("masked", {15'h0, irq}, 16'h0000);
		chg_host_model_inst.rd(8'h04, d);
		check("r04", d, 16'h1100);
		int_mask = 1'b0;
		wt(3);
		check("unmasked", {15'h0, irq}, 16'h0001);
		pend = 1'b0;
		cond = '0;
		chg_host_model_inst.rd(8'h04, d);
		check("r04", d, 16'h1000);
		check("irq", {15'h0, irq}, 16'h0000);
	endtask
	task automatic t_otg();
		chg_host_model_inst.wr(7'h35, 8'h02, 8'h00, ok);
		otg_mode = 1'b1;
		wt(1);
		otg_mode = 1'b0;
		chg_host_model_inst.rd(8'h02, d);
		check("boost", d, 16'h0600);
		chg_host_model_inst.wr(7'h35, 8'h02, 8'hff, ok);
		soft_reset = 1'b1;
		wt(1);
		soft_reset = 1'b0;
		chg_host_model_inst.rd(8'h02, d);
		check("soft", d, 16'h1600);
	endtask
	task automatic t_freeze();
		clk_en = 1'b0;
		cond = 8'h80;
		wt(8);
		check("frozen irq", {15'h0, irq}, 16'h0000);
		clk_en = 1'b1;
		wt(6);
		check("thawed irq", {15'h0, irq}, 16'h0001);
		cond = '0;
		wt(6);
		chg_host_model_inst.rd(8'h03, d);
		check("warm flag", d, 16'h2000);
	endtask
	task automatic print_verdict();
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	initial begin
		wt(12);
		resetn = 1'b1;
		wt(6);
		t_reset();
		t_ctrl();
		t_refuse();
		t_flags();
		t_otg();
		t_mask();
		t_freeze();
		print_verdict();
	end
	initial begin
		#800_000;
		n_errors++;
		print_verdict();
	end
endmodule
`default_nettype wire
